// File: acs_pkg.sv
// Package with register map, field layout and timing constants of the calibration scaler.
package acs_pkg;
  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ACS_OFS_ADDR     = 8'h00;
  localparam logic [7:0] ACS_GAIN_ADDR    = 8'h04;
  localparam logic [7:0] ACS_CMD_ADDR     = 8'h08;
  localparam logic [7:0] ACS_STATUS_ADDR  = 8'h0C;
  localparam logic [7:0] ACS_RESULT_ADDR  = 8'h10;
  // ---------------------------------------------------------------------------
  // Reset values and codes
  // ---------------------------------------------------------------------------
  localparam logic [23:0] ACS_OFS_RESET   = 24'h000000;
  localparam logic [23:0] ACS_GAIN_RESET  = 24'h400000;
  localparam int          ACS_GAIN_SHIFT  = 22;
  localparam logic [15:0] ACS_POS_CLIP    = 16'h7FFF;
  localparam logic [15:0] ACS_NEG_CLIP    = 16'h8000;
  // Command field codes, bits [1:0] of the command register.
  localparam logic [1:0]  ACS_CMD_SYS_OFS  = 2'h1;
  localparam logic [1:0]  ACS_CMD_SELF_OFS = 2'h2;
  localparam logic [1:0]  ACS_CMD_SYS_GAIN = 2'h3;
  localparam int          ACS_CMD_SLEEP_BIT = 2;
  // Status bits.
  localparam int          ACS_ST_BUSY     = 0;
  localparam int          ACS_ST_PDOWN    = 1;
  localparam int          ACS_ST_SHORT    = 2;
  localparam int          ACS_ST_DONE_N   = 3;
  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int          ACS_CAL_SAMPLES = 16;
  localparam int          ACS_AVG_SHIFT   = 4;
  localparam int          ACS_SYS_CLKS    = 50;
  localparam int          ACS_MOD_CLKS    = 32;
  typedef enum logic [3:0] {
    ACS_IDLE   = 4'b0001,
    ACS_SETUP  = 4'b0010,
    ACS_ACCUM  = 4'b0100,
    ACS_FINISH = 4'b1000
  } acs_state_t;
endpackage

// File: acs_scaler.sv
// Calibration scaler: offset and gain correction, clipping and calibration sequencer with AHB-Lite slave.
`timescale 1ns/1ns
// Summary of operation
// - Output equals filter word minus offset, then multiplied by gain.
// - Gain is unsigned 24 bits, 400000h is unity; product divided by 400000h.
// - Scaled result saturates into the 16-bit signed range.
// - Offset and gain load from host writes or calibration results.
// - Offset is a 24-bit twos-complement word, 800000h to 7FFFFFh.
// - Upper offset bytes align to output code; low byte corrects sub-LSB.
// - Offset zero leaves filter output unchanged.
// - Three calibration commands: system gain, system offset, self offset.
// - Calibration end drives active-low done output low.
// - First result after calibration is valid, not discarded.
// - Stop or sleep during calibration powers down after calibration ends.
// - Self offset calibration shorts inputs internally to mid-supply.
// - Offset calibrations write new value into offset register.
// - A calibration command written while idle aborts current conversion and starts at once; one written while busy only pulses filt_restart.
// - Gain calibration writes new value into gain register.
// - Calibration averages sixteen consecutive conversions.
// - Calibration lasts 50 system clocks, 32 modulator clocks, sixteen data periods.
// - Output is twos complement, clipping at 7FFFh and 8000h.
module acs_scaler (
  // AHB-Lite slave
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Filter side
  input  wire logic [23:0] filt_data,
  input  wire logic        filt_valid,
  input  wire logic        mod_tick,
  input  wire logic        start_pin,
  output logic             filt_restart,
  output logic             input_short,
  output logic             power_down,
  // Result side
  output logic      [15:0] result_data,
  output logic             result_valid,
  output logic             conversion_done_n
);
  import acs_pkg::*;

  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  logic [1:0] start_sync_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // Reset to the pin's idle high level so no false power-down follows reset.
      start_sync_r <= 2'b11;
    end else begin
      start_sync_r <= {start_sync_r[0], start_pin};
    end
  end
  logic start_lvl;
  assign start_lvl = start_sync_r[1];

  // ---------------------------------------------------------------------------
  // Scaling datapath
  // ---------------------------------------------------------------------------
  // Offset is kept as 24 bits so its low byte gives sub-LSB correction.
  function automatic logic [15:0] acs_scale(input logic [23:0] din, input logic [23:0] ofs,
                                            input logic [23:0] gain);
    logic signed [24:0] diff;
    logic signed [49:0] prod;
    logic signed [49:0] q;
    diff = $signed({din[23], din}) - $signed({ofs[23], ofs});
    prod = $signed({{25{diff[24]}}, diff}) * $signed({26'h0, gain});
    q    = prod >>> (ACS_GAIN_SHIFT + 8);
    if (q > $signed({{34{1'b0}}, ACS_POS_CLIP})) begin
      acs_scale = ACS_POS_CLIP;
    end else if (q < $signed({{34{1'b1}}, ACS_NEG_CLIP})) begin
      acs_scale = ACS_NEG_CLIP;
    end else begin
      acs_scale = q[15:0];
    end
  endfunction

  // ---------------------------------------------------------------------------
  // Registers and AHB-Lite slave
  // ---------------------------------------------------------------------------
  logic [23:0] ofs_r;
  logic [23:0] gain_r;
  logic        ap_wr_r;
  logic [7:0]  ap_addr_r;
  logic        cmd_wr;
  logic        ap_valid;
  assign ap_valid = hsel & hready & htrans[1];
  assign cmd_wr   = ap_wr_r & (ap_addr_r == ACS_CMD_ADDR);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_r   <= 1'b0;
      ap_addr_r <= 8'h00;
    end else begin
      ap_wr_r   <= ap_valid & hwrite;
      ap_addr_r <= haddr[7:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Calibration sequencer
  // ---------------------------------------------------------------------------
  acs_state_t  state_r;
  logic [1:0]  cal_kind_r;
  logic [4:0]  cnt_r;
  logic [5:0]  setup_r;
  logic [28:0] acc_r;
  logic        pd_pend_r;
  logic        pd_r;
  logic        cal_start;
  logic [1:0]  cmd_code;
  logic        sleep_req;
  logic [23:0] avg;
  assign cmd_code  = hwdata[1:0];
  assign sleep_req = cmd_wr & hwdata[ACS_CMD_SLEEP_BIT];
  assign cal_start = cmd_wr & (cmd_code != 2'h0);
  assign avg       = acc_r[27:4];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r    <= ACS_IDLE;
      cal_kind_r <= 2'h0;
      cnt_r      <= 5'h00;
      setup_r    <= 6'h00;
      acc_r      <= 29'h0;
    end else begin
      case (state_r)
        ACS_IDLE: begin
          if (cal_start) begin
            state_r    <= ACS_SETUP;
            cal_kind_r <= cmd_code;
            setup_r    <= 6'h00;
            cnt_r      <= 5'h00;
            acc_r      <= 29'h0;
          end
        end
        ACS_SETUP: begin
          // Fifty system clocks, then 32 modulator ticks of filter restart.
          if (setup_r < 6'(ACS_SYS_CLKS)) begin
            setup_r <= setup_r + 6'h01;
          end else if (cnt_r == 5'(ACS_MOD_CLKS - 1) && mod_tick) begin
            cnt_r   <= 5'h00;
            state_r <= ACS_ACCUM;
          end else if (mod_tick) begin
            cnt_r <= cnt_r + 5'h01;
          end
        end
        ACS_ACCUM: begin
          if (filt_valid) begin
            acc_r <= acc_r + {{5{filt_data[23]}}, filt_data};
            if (cnt_r == 5'(ACS_CAL_SAMPLES - 1)) begin
              state_r <= ACS_FINISH;
            end else begin
              cnt_r <= cnt_r + 5'h01;
            end
          end
        end
        ACS_FINISH: begin
          state_r <= ACS_IDLE;
        end
        default: begin
          state_r <= ACS_IDLE;
        end
      endcase
    end
  end

  // Correction registers: host writes or calibration results.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ofs_r  <= ACS_OFS_RESET;
      gain_r <= ACS_GAIN_RESET;
    end else if (state_r == ACS_FINISH) begin
      if (cal_kind_r == ACS_CMD_SYS_GAIN) begin
        // Gain that maps the averaged full-scale input to 7FFFh.
        gain_r <= acs_gain(avg, ofs_r);
      end else begin
        // Storing the average as the subtrahend realises the negated correction.
        ofs_r <= avg;
      end
    end else if (ap_wr_r && state_r == ACS_IDLE) begin
      if (ap_addr_r == ACS_OFS_ADDR) begin
        ofs_r <= hwdata[23:0];
      end
      if (ap_addr_r == ACS_GAIN_ADDR) begin
        gain_r <= hwdata[23:0];
      end
    end
  end

  // Gain chosen so that (avg - ofs) * gain / 400000h lands on full scale.
  function automatic logic [23:0] acs_gain(input logic [23:0] a, input logic [23:0] o);
    logic signed [24:0] d;
    logic [47:0]        num;
    logic [47:0]        q;
    d   = $signed({a[23], a}) - $signed({o[23], o});
    num = 48'h7FFF00 << ACS_GAIN_SHIFT;
    if (d <= 0) begin
      acs_gain = ACS_GAIN_RESET;
    end else begin
      q = num / {23'h0, d[24:0]};
      acs_gain = (q > 48'hFFFFFF) ? 24'hFFFFFF : q[23:0];
    end
  endfunction

  // Power-down after any pending stop or sleep once calibration is over.
  logic busy;
  assign busy = (state_r != ACS_IDLE);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pd_pend_r <= 1'b0;
      pd_r      <= 1'b0;
    end else begin
      if (sleep_req || !start_lvl) begin
        pd_pend_r <= 1'b1;
      end else if (!busy) begin
        pd_pend_r <= 1'b0;
      end
      if (!busy && (pd_pend_r || sleep_req || !start_lvl)) begin
        pd_r <= 1'b1;
      end else if (cal_start || (start_lvl && !pd_pend_r)) begin
        pd_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_data       <= 16'h0000;
      result_valid      <= 1'b0;
      conversion_done_n <= 1'b1;
      filt_restart      <= 1'b0;
      input_short       <= 1'b0;
      power_down        <= 1'b0;
    end else begin
      filt_restart <= cal_start || state_r == ACS_SETUP;
      input_short  <= busy && cal_kind_r == ACS_CMD_SELF_OFS;
      power_down   <= pd_r;
      // No settling discard after calibration; each valid word is passed on.
      result_valid <= filt_valid && !busy && !pd_r;
      if (filt_valid && !busy && !pd_r) begin
        result_data <= acs_scale(filt_data, ofs_r, gain_r);
      end
      if (state_r == ACS_FINISH || (filt_valid && !busy && !pd_r)) begin
        conversion_done_n <= 1'b0;
      end else if (ap_valid && !hwrite && haddr[7:0] == ACS_RESULT_ADDR) begin
        conversion_done_n <= 1'b1;
      end
    end
  end

  // Read data and response; zero wait states, always OKAY.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (ap_valid && !hwrite) begin
        case (haddr[7:0])
          ACS_OFS_ADDR:    hrdata <= {8'h00, ofs_r};
          ACS_GAIN_ADDR:   hrdata <= {8'h00, gain_r};
          ACS_STATUS_ADDR: hrdata <= {28'h0, conversion_done_n, input_short, pd_r, busy};
          ACS_RESULT_ADDR: hrdata <= {16'h0000, result_data};
          default:         hrdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // acs_scaler

// File: acs_scaler_monitor.sv
// Checker of the calibration scaler ports.
`timescale 1ns/1ns
module acs_scaler_monitor
  import acs_pkg::*;
(
  // Bus side
  input wire logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
  input wire logic [31:0] haddr, hwdata, hrdata,
  input wire logic [1:0]  htrans,
  // Filter and result side
  input wire logic        filt_valid, filt_restart, input_short, power_down,
  input wire logic        result_valid, conversion_done_n
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence cmd_wr_s;
    hsel && hready && htrans[1] && hwrite && (haddr[7:0] == ACS_CMD_ADDR);
  endsequence
  sequence rd_void_s;
    hsel && hready && htrans[1] && !hwrite && (haddr[7:0] == 8'h14);
  endsequence
  ready_high_a: assert property (hreadyout) else $error("bus stall seen");
  resp_okay_a: assert property (!hresp) else $error("error response seen");
  result_cause_a: assert property (result_valid |-> $past(filt_valid))
    else $error("result without conversion");
  done_result_a: assert property (result_valid |-> ##[0:1] !conversion_done_n)
    else $error("done flag missing after result");
  cal_abort_a: assert property (cmd_wr_s ##1 (hwdata[1:0] != 2'h0) |-> ##[0:2] filt_restart)
    else $error("conversion not aborted");
  self_short_a: assert property (cmd_wr_s ##1 (hwdata[1:0] == ACS_CMD_SELF_OFS) |-> ##[0:2] input_short)
    else $error("inputs not shorted");
  pdown_cal_a: assert property (filt_restart |-> !power_down)
    else $error("power down during calibration");
  void_zero_a: assert property (rd_void_s |=> (hrdata == 32'h0)) else $error("unmapped read not zero");
endmodule // acs_scaler_monitor
bind acs_scaler acs_scaler_monitor i_mon (.hclk, .hresetn, .hsel, .hwrite, .hready, .hreadyout, .hresp, .haddr,
  .hwdata, .hrdata, .htrans, .filt_valid, .filt_restart, .input_short, .power_down, .result_valid, .conversion_done_n);

// File: acs_filter_model.sv
// Behavioural model of the filter and modulator feeding the scaler.
`timescale 1ns/1ns
module acs_filter_model (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Run request
  input  wire logic        go,
  input  wire logic [7:0]  count,
  input  wire logic [23:0] cdata,
  // Conversion stream
  output logic      [23:0] filt_data,
  output logic             filt_valid,
  output logic             mod_tick
);
  logic [7:0] left_r;
  logic [3:0] div_r;
  logic       fire;
  assign fire = (left_r != 8'h00) && (div_r == 4'hF);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r <= 4'h0;
      mod_tick <= 1'b0;
    end else begin
      div_r <= div_r + 4'h1;
      mod_tick <= (div_r[1:0] == 2'h3);
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      left_r <= 8'h00;
    end else if (go) begin
      left_r <= count;
    end else if (fire) begin
      left_r <= left_r - 8'h01;
    end
  end
  // Off the strobe the word toggles, so a stale sample never looks right.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filt_valid <= 1'b0;
      filt_data <= 24'h000000;
    end else begin
      filt_valid <= fire;
      filt_data <= fire ? cdata : ~filt_data;
    end
  end
endmodule // acs_filter_model

// File: test_acs_scaler.sv
// Self-checking testbench of the calibration scaler.
`timescale 1ns/1ns
module test_acs_scaler;
  import acs_pkg::*;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, start_pin = 1, go = 0, expect_on = 0, rnd_on = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0]  htrans = 0;
  logic [7:0]  cnt = 0;
  logic [23:0] cdata = 0, filt_data, ofs_m = ACS_OFS_RESET, gain_m = ACS_GAIN_RESET;
  logic        hready, hresp, filt_valid, mod_tick, filt_restart, input_short, power_down, result_valid;
  logic        conversion_done_n;
  logic [15:0] result_data;
  logic [15:0] expq[$];
  int          seed = 14225, n_errors = 0, total_checks = 0, n_seen = 0, cyc = 0;
  always #5 hclk = ~hclk;
  acs_scaler i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata,
    .hreadyout(hready), .hresp, .filt_data, .filt_valid, .mod_tick, .start_pin, .filt_restart, .input_short,
    .power_down, .result_data, .result_valid, .conversion_done_n);
  acs_filter_model i_flt (.hclk, .hresetn, .go, .count(cnt), .cdata, .filt_data, .filt_valid, .mod_tick);
  // ---------------------------------------------------------------------------
  // Checking
  // ---------------------------------------------------------------------------
  function automatic logic [15:0] exp_res(logic [23:0] f);
    logic signed [63:0] p;
    p = ($signed({{40{f[23]}}, f}) - $signed({{40{ofs_m[23]}}, ofs_m})) * $signed({40'h0, gain_m});
    p = p >>> 30;
    if (p > 64'sh7FFF) return ACS_POS_CLIP;
    if (p < -64'sh8000) return ACS_NEG_CLIP;
    return p[15:0];
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge hclk) begin
    if (rnd_on) cdata <= 24'($random(seed));
    if (filt_valid === 1'b1 && expect_on) expq.push_back(exp_res(filt_data));
    if (result_valid === 1'b1) begin
      n_seen++;
      if (expq.size() == 0) chk(1, 0);
      else chk({16'h0, result_data}, {16'h0, expq.pop_front()});
    end
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      test_done;
    end
  end
  // ---------------------------------------------------------------------------
  // Drivers
  // ---------------------------------------------------------------------------
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task run(input logic [7:0] n);
    n_seen = 0;
    expect_on = 1;
    rnd_on = 1;
    cnt <= n;
    go <= 1;
    @(posedge hclk);
    go <= 0;
    while (n_seen < n) @(posedge hclk);
    expect_on = 0;
    rnd_on = 0;
  endtask
  task conv(input logic [23:0] o, input logic [23:0] g);
    bus(1, ACS_OFS_ADDR, {8'h0, o});
    bus(1, ACS_GAIN_ADDR, {8'h0, g});
    bus(0, ACS_OFS_ADDR, 0);
    chk(rd, {8'h0, o});
    bus(0, ACS_GAIN_ADDR, 0);
    chk(rd, {8'h0, g});
    ofs_m = o;
    gain_m = g;
    run(8'h0C);
  endtask
  task cal(input logic [1:0] c, input logic [23:0] d);
    logic signed [25:0] diff;
    logic [63:0]        q;
    cdata <= d;
    bus(0, ACS_RESULT_ADDR, 0);
    bus(1, ACS_CMD_ADDR, {30'h0, c});
    if (c == ACS_CMD_SYS_GAIN) start_pin <= 0;
    // A busy block must ignore this stray write.
    bus(1, ACS_OFS_ADDR, 32'h00555555);
    repeat (250) @(posedge hclk);
    chk(input_short, c == ACS_CMD_SELF_OFS);
    chk(power_down, 0);
    cnt <= 8'h10;
    go <= 1;
    @(posedge hclk);
    go <= 0;
    do bus(0, ACS_STATUS_ADDR, 0); while (rd[ACS_ST_BUSY]);
    chk(conversion_done_n, 0);
    diff = $signed(d) - $signed(ofs_m);
    if (c != ACS_CMD_SYS_GAIN) ofs_m = d;
    else if (diff <= 0) gain_m = ACS_GAIN_RESET;
    else begin
      q = (64'h7FFF00 * 64'h400000) / {38'h0, diff};
      gain_m = (q > 64'hFFFFFF) ? 24'hFFFFFF : q[23:0];
    end
    bus(0, ACS_OFS_ADDR, 0);
    chk(rd, {8'h0, ofs_m});
    bus(0, ACS_GAIN_ADDR, 0);
    chk(rd, {8'h0, gain_m});
  endtask
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    bus(0, ACS_OFS_ADDR, 0);
    chk(rd, {8'h0, ACS_OFS_RESET});
    bus(0, ACS_GAIN_ADDR, 0);
    chk(rd, {8'h0, ACS_GAIN_RESET});
    bus(0, 8'h14, 0);
    chk(rd, 0);
    conv(ACS_OFS_RESET, ACS_GAIN_RESET);
    conv(24'h000100, 24'h800000);
    conv(24'h7FFFFF, 24'hFFFFFF);
    conv(24'h800000, 24'h200000);
    cal(ACS_CMD_SYS_OFS, 24'h000123);
    cal(ACS_CMD_SELF_OFS, 24'hFFFE00);
    cal(ACS_CMD_SYS_GAIN, 24'h3FFE00);
    repeat (4) @(posedge hclk);
    chk(power_down, 1);
    start_pin <= 1;
    repeat (8) @(posedge hclk);
    chk(power_down, 0);
    run(8'h04);
    test_done;
  end
endmodule // test_acs_scaler
